/* logic/cscr_regs.sv */
// Core status word, core control word, loop start readback and data-space address generation.
// Assumes one core clock, a synchronous reset, and that all inputs come from logic on that clock.
`timescale 1ns/1ps
`default_nettype none
`include "cscr_map.svh"

module cscr_regs (
  input wire logic CLK,
  input wire logic RST_N,
  input wire cscr_pkg::cscr_sfr_req_t SFR_REQ,
  output logic [15:0] SFR_RDATA,
  input wire cscr_pkg::cscr_alu_op_t ALU_OP,
  input wire cscr_pkg::cscr_acc_evt_t ACC_EVT,
  input wire cscr_pkg::cscr_loop_stat_t LOOP_STAT,
  input wire logic [23:0] LOOP_START_ADDR,
  input wire logic NESTING_DISABLE,
  input wire logic PRI_LOAD,
  input wire logic [3:0] PRI_VALUE,
  output logic [3:0] CPU_PRIORITY,
  output logic USER_INT_BLOCKED,
  output cscr_pkg::cscr_core_ctrl_t CORE_CTRL,
  input wire logic [1:0] ACTIVE_CTX,
  input wire logic [3:0] WREG_MM_IDX,
  output logic [1:0] WREG_MM_BANK,
  input wire cscr_pkg::cscr_agu_cfg_t X_CFG,
  input wire cscr_pkg::cscr_agu_cfg_t Y_CFG,
  input wire cscr_pkg::cscr_agu_req_t AGU_REQ,
  output cscr_pkg::cscr_agu_out_t AGU_OUT
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Post-modify with circular wrap inside [start, end]
  function automatic logic [15:0] modulo_next(input logic [15:0] ea, input logic [15:0] step,
                                              input cscr_pkg::cscr_agu_cfg_t cfg);
    logic [15:0] n;
    n = ea + step;
    if (cfg.mod_en && !step[15] && n > cfg.mod_end) begin
      n = cfg.mod_start + (n - cfg.mod_end - 16'h0001);
    end else if (cfg.mod_en && step[15] && n < cfg.mod_start) begin
      n = cfg.mod_end - (cfg.mod_start - n - 16'h0001);
    end
    return n;
  endfunction : modulo_next

  // Mirror a 16-bit word
  function automatic logic [15:0] mirror16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : mirror16

  // ****************************************************************
  // State
  // ****************************************************************
  logic oa_q, oa_d, ob_q, ob_d, sa_q, sa_d, sb_q, sb_d;
  logic da_q, da_d, ra_q, ra_d, dc_q, dc_d;
  logic n_q, n_d, ov_q, ov_d, z_q, z_d, c_q, c_d;
  logic [2:0] ipl_q, ipl_d;
  logic priority_level_msb_q, priority_level_msb_d;
  logic [2:0] dl_q, dl_d;
  logic sfa_q, sfa_d;
  logic var_q, var_d, sata_q, sata_d, satb_q, satb_d, satdw_q, satdw_d;
  logic range_q, range_d, rnd_q, rnd_d, if_q, if_d, edt_q, edt_d;
  logic [1:0] us_q, us_d;
  logic [15:0] rdata_q, rdata_d;
  logic [1:0] bank_q, bank_d;
  cscr_pkg::cscr_agu_out_t agu_q, agu_d;

  logic wr_sr, wr_cc;
  logic [15:0] wd;
  logic [15:0] b_op;
  logic cin;
  logic [16:0] sum17;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic res_msb, a_msb, b_msb, res_zero;
  logic [15:0] sr_view, cc_view;

  assign wr_sr = SFR_REQ.wr && SFR_REQ.addr == `CSCR_IDX_STATUS;
  assign wr_cc = SFR_REQ.wr && SFR_REQ.addr == `CSCR_IDX_CONTROL;
  assign wd = SFR_REQ.wdata;

  // ****************************************************************
  // ALU flag arithmetic
  // ****************************************************************

  // Subtract adds the inverted operand plus one, so carry is the inverted borrow
  assign b_op = ALU_OP.subtract ? ~ALU_OP.b : ALU_OP.b;
  assign cin = ALU_OP.subtract;
  assign sum17 = {1'b0, ALU_OP.a} + {1'b0, b_op} + {16'h0000, cin};
  assign sum9 = {1'b0, ALU_OP.a[7:0]} + {1'b0, b_op[7:0]} + {8'h00, cin};
  assign sum5 = {1'b0, ALU_OP.a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
  assign res_msb = ALU_OP.byte_mode ? sum9[7] : sum17[15];
  assign a_msb = ALU_OP.byte_mode ? ALU_OP.a[7] : ALU_OP.a[15];
  assign b_msb = ALU_OP.byte_mode ? b_op[7] : b_op[15];
  assign res_zero = ALU_OP.byte_mode ? (sum9[7:0] == 8'h00) : (sum17[15:0] == 16'h0000);

  // ****************************************************************
  // Status word next values
  // ****************************************************************

  // Software write first, then hardware events, so a same-cycle event is never lost
  always_comb begin
    oa_d = oa_q;
    ob_d = ob_q;
    sa_d = sa_q;
    sb_d = sb_q;
    ipl_d = ipl_q;
    dc_d = dc_q;
    n_d = n_q;
    ov_d = ov_q;
    z_d = z_q;
    c_d = c_q;
    if (wr_sr) begin
      oa_d = wd[`CSCR_SR_OA];
      ob_d = wd[`CSCR_SR_OB];
      if (!wd[`CSCR_SR_OAB]) begin
        oa_d = 1'b0;
        ob_d = 1'b0;
      end
      if (!wd[`CSCR_SR_SAB]) begin
        sa_d = 1'b0;
        sb_d = 1'b0;
      end else begin
        sa_d = wd[`CSCR_SR_SA];
        sb_d = wd[`CSCR_SR_SB];
      end
      if (!NESTING_DISABLE) begin
        ipl_d = wd[`CSCR_SR_IPL_HI:`CSCR_SR_IPL_LO];
      end
      dc_d = wd[`CSCR_SR_DC];
      n_d = wd[`CSCR_SR_N];
      ov_d = wd[`CSCR_SR_OV];
      z_d = wd[`CSCR_SR_Z];
      c_d = wd[`CSCR_SR_C];
    end
    // Overflow bits follow each accumulator write-back
    if (ACC_EVT.upd_a) begin
      oa_d = ACC_EVT.ov_a;
    end
    if (ACC_EVT.upd_b) begin
      ob_d = ACC_EVT.ov_b;
    end
    // Saturation only ever sets; clearing is software's job
    sa_d = sa_d | (ACC_EVT.upd_a & ACC_EVT.sat_a);
    sb_d = sb_d | (ACC_EVT.upd_b & ACC_EVT.sat_b);
    if (PRI_LOAD) begin
      ipl_d = PRI_VALUE[2:0];
    end
    if (ALU_OP.valid) begin
      dc_d = ALU_OP.byte_mode ? sum5[4] : sum9[8];
      n_d = res_msb;
      ov_d = (a_msb == b_msb) && (res_msb != a_msb);
      z_d = res_zero;
      c_d = ALU_OP.byte_mode ? sum9[8] : sum17[16];
    end
  end

  // Loop indicators are mirrors of sequencer state, never written by software
  always_comb begin
    da_d = LOOP_STAT.do_active;
    ra_d = LOOP_STAT.rep_active;
    dl_d = LOOP_STAT.nest_depth;
    sfa_d = LOOP_STAT.stack_frame;
  end

  // ****************************************************************
  // Control word next values
  // ****************************************************************

  // Priority msb is clear-only for software; the interrupt controller sets it
  always_comb begin
    var_d = var_q;
    us_d = us_q;
    sata_d = sata_q;
    satb_d = satb_q;
    satdw_d = satdw_q;
    range_d = range_q;
    rnd_d = rnd_q;
    if_d = if_q;
    priority_level_msb_d = priority_level_msb_q;
    edt_d = 1'b0;
    if (wr_cc) begin
      var_d = wd[`CSCR_CC_VAR];
      us_d = wd[`CSCR_CC_US_HI:`CSCR_CC_US_LO];
      edt_d = wd[`CSCR_CC_EDT];
      sata_d = wd[`CSCR_CC_SATA];
      satb_d = wd[`CSCR_CC_SATB];
      satdw_d = wd[`CSCR_CC_SATDW];
      range_d = wd[`CSCR_CC_RANGE];
      rnd_d = wd[`CSCR_CC_RND];
      if_d = wd[`CSCR_CC_IF];
      if (!wd[`CSCR_CC_PRIORITY_LEVEL_MSB]) begin
        priority_level_msb_d = 1'b0;
      end
    end
    if (PRI_LOAD) begin
      priority_level_msb_d = PRI_VALUE[3];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  assign sr_view = {oa_q, ob_q, sa_q, sb_q, oa_q | ob_q, sa_q | sb_q, da_q, dc_q,
                    ipl_q, ra_q, n_q, ov_q, z_q, c_q};
  // Early termination is a strobe and always reads back zero
  assign cc_view = {var_q, 1'b0, us_q, 1'b0, dl_q, sata_q, satb_q, satdw_q, range_q,
                    priority_level_msb_q, sfa_q, rnd_q, if_q};

  // Read data is registered: it appears one clock after the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (SFR_REQ.rd) begin
      if (SFR_REQ.addr == `CSCR_IDX_STATUS) begin
        rdata_d = sr_view;
      end else if (SFR_REQ.addr == `CSCR_IDX_CONTROL) begin
        rdata_d = cc_view;
      end else if (SFR_REQ.addr == `CSCR_IDX_LSTART_LO) begin
        rdata_d = LOOP_START_ADDR[15:0];
      end else begin
        rdata_d = {8'h00, LOOP_START_ADDR[23:16]};
      end
    end
  end

  // ****************************************************************
  // Address generation
  // ****************************************************************

  // Bit-reversed stepping adds the modifier with the carry running downward
  always_comb begin
    agu_d = '0;
    bank_d = (WREG_MM_IDX == `CSCR_SHADOW_REG) ? 2'h0 : ACTIVE_CTX;
    if (AGU_REQ.valid) begin
      agu_d.x_valid = 1'b1;
      agu_d.y_valid = AGU_REQ.dual;
      if (AGU_REQ.brev_en) begin
        agu_d.x_next = mirror16(mirror16(AGU_REQ.x_ea) + mirror16(AGU_REQ.brev_mod));
      end else begin
        agu_d.x_next = modulo_next(AGU_REQ.x_ea, AGU_REQ.x_step, X_CFG);
      end
      if (AGU_REQ.dual) begin
        agu_d.y_next = modulo_next(AGU_REQ.y_ea, AGU_REQ.y_step, Y_CFG);
      end
      agu_d.x_in_base = AGU_REQ.x_ea < `CSCR_BASE_BYTES;
      agu_d.x_prog_hit = AGU_REQ.win_en && AGU_REQ.x_ea[15];
      if (agu_d.x_prog_hit) begin
        agu_d.prog_word = {AGU_REQ.win_page, AGU_REQ.x_ea[14:1]};
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // All flags clear at reset; only the data-write saturation enable starts set
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      {oa_q, ob_q, sa_q, sb_q, da_q, ra_q, dc_q} <= 7'h00;
      {n_q, ov_q, z_q, c_q} <= 4'h0;
      ipl_q <= 3'h0;
      priority_level_msb_q <= 1'b0;
      dl_q <= 3'h0;
      sfa_q <= 1'b0;
      {var_q, sata_q, satb_q, range_q, rnd_q, if_q, edt_q} <= 7'h00;
      satdw_q <= `CSCR_CC_SATDW_RST;
      us_q <= 2'h0;
      rdata_q <= 16'h0000;
      bank_q <= 2'h0;
      agu_q <= '0;
    end else begin
      oa_q <= oa_d;
      ob_q <= ob_d;
      sa_q <= sa_d;
      sb_q <= sb_d;
      da_q <= da_d;
      ra_q <= ra_d;
      dc_q <= dc_d;
      n_q <= n_d;
      ov_q <= ov_d;
      z_q <= z_d;
      c_q <= c_d;
      ipl_q <= ipl_d;
      priority_level_msb_q <= priority_level_msb_d;
      dl_q <= dl_d;
      sfa_q <= sfa_d;
      var_q <= var_d;
      sata_q <= sata_d;
      satb_q <= satb_d;
      satdw_q <= satdw_d;
      range_q <= range_d;
      rnd_q <= rnd_d;
      if_q <= if_d;
      edt_q <= edt_d;
      us_q <= us_d;
      rdata_q <= rdata_d;
      bank_q <= bank_d;
      agu_q <= agu_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign SFR_RDATA = rdata_q;
  assign CPU_PRIORITY = {priority_level_msb_q, ipl_q};
  assign USER_INT_BLOCKED = priority_level_msb_q | (ipl_q == `CSCR_TOP_PRIO);
  assign CORE_CTRL = {var_q, us_q, edt_q, sata_q, satb_q, satdw_q, range_q, rnd_q, if_q};
  assign WREG_MM_BANK = bank_q;
  assign AGU_OUT = agu_q;

endmodule : cscr_regs

`default_nettype wire

/* pkg/cscr_map.svh */
// Offsets, field positions and reset values of the core status and control registers.
// Assumes inclusion by bare name from the design file; the package file does not include it.
`ifndef CSCR_MAP_SVH
`define CSCR_MAP_SVH

// ****************************************************************
// Register indices on the memory-mapped special function port
// ****************************************************************
`define CSCR_IDX_STATUS 2'h0
`define CSCR_IDX_CONTROL 2'h1
`define CSCR_IDX_LSTART_LO 2'h2
`define CSCR_IDX_LSTART_HI 2'h3

// ****************************************************************
// Status word field positions
// ****************************************************************
`define CSCR_SR_OA 15
`define CSCR_SR_OB 14
`define CSCR_SR_SA 13
`define CSCR_SR_SB 12
`define CSCR_SR_OAB 11
`define CSCR_SR_SAB 10
`define CSCR_SR_DA 9
`define CSCR_SR_DC 8
`define CSCR_SR_IPL_HI 7
`define CSCR_SR_IPL_LO 5
`define CSCR_SR_RA 4
`define CSCR_SR_N 3
`define CSCR_SR_OV 2
`define CSCR_SR_Z 1
`define CSCR_SR_C 0

// ****************************************************************
// Control word field positions and reset values
// ****************************************************************
`define CSCR_CC_VAR 15
`define CSCR_CC_US_HI 13
`define CSCR_CC_US_LO 12
`define CSCR_CC_EDT 11
`define CSCR_CC_SATA 7
`define CSCR_CC_SATB 6
`define CSCR_CC_SATDW 5
`define CSCR_CC_RANGE 4
`define CSCR_CC_PRIORITY_LEVEL_MSB 3
`define CSCR_CC_RND 1
`define CSCR_CC_IF 0
`define CSCR_CC_SATDW_RST 1'h1

// ****************************************************************
// Addressing and priority constants
// ****************************************************************
`define CSCR_BASE_BYTES 16'h2000
`define CSCR_TOP_PRIO 3'h7
`define CSCR_SHADOW_REG 4'hf

`endif

/* pkg/cscr_pkg.sv */
// Types shared by the core status and control register block and its surroundings.
// Assumes cscr_map.svh is on the include path.
package cscr_pkg;

  // Register access from the instruction pipeline
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [15:0] wdata;
  } cscr_sfr_req_t;

  // Completed MCU ALU add or subtract
  typedef struct packed {
    logic valid;
    logic byte_mode;
    logic subtract;
    logic [15:0] a;
    logic [15:0] b;
  } cscr_alu_op_t;

  // Accumulator write-back events from the DSP engine
  typedef struct packed {
    logic upd_a;
    logic ov_a;
    logic sat_a;
    logic upd_b;
    logic ov_b;
    logic sat_b;
  } cscr_acc_evt_t;

  // Loop and stack frame state from the sequencer
  typedef struct packed {
    logic do_active;
    logic rep_active;
    logic [2:0] nest_depth;
    logic stack_frame;
  } cscr_loop_stat_t;

  // Engine settings driven out of the control word
  typedef struct packed {
    logic var_latency;
    logic [1:0] mul_sign;
    logic early_term;
    logic sat_a_en;
    logic sat_b_en;
    logic sat_dw_en;
    logic clamp_range_select;
    logic round_biased;
    logic int_mode;
  } cscr_core_ctrl_t;

  // Modulo window of one address space
  typedef struct packed {
    logic mod_en;
    logic [15:0] mod_start;
    logic [15:0] mod_end;
  } cscr_agu_cfg_t;

  // Address generation request
  typedef struct packed {
    logic valid;
    logic dual;
    logic [15:0] x_ea;
    logic [15:0] x_step;
    logic [15:0] y_ea;
    logic [15:0] y_step;
    logic brev_en;
    logic [15:0] brev_mod;
    logic win_en;
    logic [8:0] win_page;
  } cscr_agu_req_t;

  // Address generation result
  typedef struct packed {
    logic x_valid;
    logic y_valid;
    logic [15:0] x_next;
    logic [15:0] y_next;
    logic x_in_base;
    logic x_prog_hit;
    logic [22:0] prog_word;
  } cscr_agu_out_t;

endpackage : cscr_pkg

/* sim/cscr_regs_assertions.sv */
// Port-level checker for the core status and control register block.
// Assumes it is bound to cscr_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module cscr_regs_assertions (
  input wire logic CLK,
  input wire logic RST_N,
  input wire cscr_pkg::cscr_sfr_req_t SFR_REQ,
  input wire logic [15:0] SFR_RDATA,
  input wire cscr_pkg::cscr_alu_op_t ALU_OP,
  input wire cscr_pkg::cscr_acc_evt_t ACC_EVT,
  input wire cscr_pkg::cscr_loop_stat_t LOOP_STAT,
  input wire logic [23:0] LOOP_START_ADDR,
  input wire logic NESTING_DISABLE,
  input wire logic PRI_LOAD,
  input wire logic [3:0] PRI_VALUE,
  input wire logic [3:0] CPU_PRIORITY,
  input wire logic USER_INT_BLOCKED,
  input wire cscr_pkg::cscr_core_ctrl_t CORE_CTRL,
  input wire logic [1:0] ACTIVE_CTX,
  input wire logic [3:0] WREG_MM_IDX,
  input wire logic [1:0] WREG_MM_BANK,
  input wire cscr_pkg::cscr_agu_cfg_t X_CFG,
  input wire cscr_pkg::cscr_agu_cfg_t Y_CFG,
  input wire cscr_pkg::cscr_agu_req_t AGU_REQ,
  input wire cscr_pkg::cscr_agu_out_t AGU_OUT
);
  // ****************************************************************
  // Properties, all on the core clock
  // ****************************************************************
  default clocking dflt_cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  blocked_decode_a:
    assert property (USER_INT_BLOCKED == (CPU_PRIORITY[3] || (CPU_PRIORITY[2:0] == 3'h7)))
    else $error("user block flag disagrees with priority");
  pri_load_a:
    assert property (PRI_LOAD |=> CPU_PRIORITY == $past(PRI_VALUE))
    else $error("priority load not taken");
  pri_locked_a:
    assert property (NESTING_DISABLE && !PRI_LOAD && SFR_REQ.wr && SFR_REQ.addr == 2'h0
                     |=> CPU_PRIORITY[2:0] == $past(CPU_PRIORITY[2:0]))
    else $error("priority changed while locked");
  agu_idle_a:
    assert property (!AGU_REQ.valid |=> AGU_OUT == '0)
    else $error("address result without request");
  agu_pair_a:
    assert property (AGU_REQ.valid |=> AGU_OUT.x_valid && (AGU_OUT.y_valid == $past(AGU_REQ.dual)))
    else $error("address valid flags wrong");
  base_span_a:
    assert property (AGU_REQ.valid |=> AGU_OUT.x_in_base == ($past(AGU_REQ.x_ea) < 16'h2000))
    else $error("base space decode wrong");
  win_map_a:
    assert property (AGU_REQ.valid && AGU_REQ.win_en && AGU_REQ.x_ea[15]
                     |=> AGU_OUT.x_prog_hit && AGU_OUT.prog_word == {$past(AGU_REQ.win_page), $past(AGU_REQ.x_ea[14:1])})
    else $error("program window mapping wrong");
  ctx_bank_a:
    assert property ($past(RST_N) |-> WREG_MM_BANK == (($past(WREG_MM_IDX) == 4'hf) ? 2'h0 : $past(ACTIVE_CTX)))
    else $error("working register bank wrong");
  ovf_merge_a:
    assert property (SFR_REQ.rd && SFR_REQ.addr == 2'h0 |=> SFR_RDATA[11] == (SFR_RDATA[15] || SFR_RDATA[14]))
    else $error("combined overflow bit wrong");
  sticky_merge_a:
    assert property (SFR_REQ.rd && SFR_REQ.addr == 2'h0 |=> SFR_RDATA[10] == (SFR_RDATA[13] || SFR_RDATA[12]))
    else $error("combined sticky bit wrong");
  lstart_hi_a:
    assert property (SFR_REQ.rd && SFR_REQ.addr == 2'h3 |=> SFR_RDATA == {8'h00, $past(LOOP_START_ADDR[23:16])})
    else $error("loop start high readback wrong");
  loop_mirror_a:
    assert property ($past(RST_N) && SFR_REQ.rd && SFR_REQ.addr == 2'h0 && $stable(LOOP_STAT)
                     |=> SFR_RDATA[9] == $past(LOOP_STAT.do_active) && SFR_RDATA[4] == $past(LOOP_STAT.rep_active))
    else $error("loop activity bits wrong");
endmodule : cscr_regs_assertions

bind cscr_regs cscr_regs_assertions u_cscr_regs_assertions (
  .CLK(CLK), .RST_N(RST_N), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA), .ALU_OP(ALU_OP), .ACC_EVT(ACC_EVT),
  .LOOP_STAT(LOOP_STAT), .LOOP_START_ADDR(LOOP_START_ADDR), .NESTING_DISABLE(NESTING_DISABLE),
  .PRI_LOAD(PRI_LOAD), .PRI_VALUE(PRI_VALUE), .CPU_PRIORITY(CPU_PRIORITY), .USER_INT_BLOCKED(USER_INT_BLOCKED),
  .CORE_CTRL(CORE_CTRL), .ACTIVE_CTX(ACTIVE_CTX), .WREG_MM_IDX(WREG_MM_IDX), .WREG_MM_BANK(WREG_MM_BANK),
  .X_CFG(X_CFG), .Y_CFG(Y_CFG), .AGU_REQ(AGU_REQ), .AGU_OUT(AGU_OUT)
);
`default_nettype wire

/* sim/tb_cscr_regs.sv */
// Self-checking bench for the core status and control register block.
// Assumes cscr_pkg and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_cscr_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cscr_pkg::cscr_sfr_req_t sfr_req = '0;
  cscr_pkg::cscr_alu_op_t alu_op = '0;
  cscr_pkg::cscr_acc_evt_t acc_evt = '0;
  cscr_pkg::cscr_loop_stat_t loop_stat = '0;
  cscr_pkg::cscr_agu_cfg_t x_cfg = '0;
  cscr_pkg::cscr_agu_cfg_t y_cfg = '0;
  cscr_pkg::cscr_agu_req_t agu_req = '0;
  cscr_pkg::cscr_agu_out_t agu_out;
  cscr_pkg::cscr_core_ctrl_t core_ctrl;
  logic [23:0] loop_start = 24'h0;
  logic nest_dis = 1'b0;
  logic pri_load = 1'b0;
  logic [3:0] pri_value = 4'h0;
  logic [1:0] act_ctx = 2'h0;
  logic [3:0] mm_idx = 4'h0;
  logic [15:0] sfr_rdata;
  logic [3:0] cpu_prio;
  logic user_blk;
  logic [1:0] mm_bank;
  logic rd_dly = 1'b0;
  logic [15:0] exp_q[$];
  int error_cnt = 0;
  int total_checks = 0;

  // ****************************************************************
  // Clock, design and helpers
  // ****************************************************************
  always #50 clk = ~clk;

  cscr_regs u_cscr_regs (
    .CLK(clk), .RST_N(rst_n), .SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata), .ALU_OP(alu_op), .ACC_EVT(acc_evt),
    .LOOP_STAT(loop_stat), .LOOP_START_ADDR(loop_start), .NESTING_DISABLE(nest_dis), .PRI_LOAD(pri_load),
    .PRI_VALUE(pri_value), .CPU_PRIORITY(cpu_prio), .USER_INT_BLOCKED(user_blk), .CORE_CTRL(core_ctrl),
    .ACTIVE_CTX(act_ctx), .WREG_MM_IDX(mm_idx), .WREG_MM_BANK(mm_bank), .X_CFG(x_cfg), .Y_CFG(y_cfg),
    .AGU_REQ(agu_req), .AGU_OUT(agu_out)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // Read data shows one cycle after the request; compare with the oldest note
  always @(posedge clk) rd_dly <= sfr_req.rd && rst_n;
  always @(negedge clk) begin
    if (rd_dly && exp_q.size() == 0) begin
      check(32'h0, 32'h1);
    end else if (rd_dly) begin
      check(32'(sfr_rdata), 32'(exp_q.pop_front()));
    end
  end

  task automatic sfr_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    sfr_req <= '0;
    @(negedge clk);
  endtask : sfr_wr

  task automatic sfr_rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
    exp_q.push_back(e);
    @(posedge clk);
    sfr_req <= '0;
    @(negedge clk);
  endtask : sfr_rd

  task automatic alu(input logic bm, input logic sb, input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    alu_op <= '{valid: 1'b1, byte_mode: bm, subtract: sb, a: a, b: b};
    @(posedge clk);
    alu_op.valid <= 1'b0;
  endtask : alu

  task automatic acc(input cscr_pkg::cscr_acc_evt_t e);
    @(posedge clk);
    acc_evt <= e;
    @(posedge clk);
    acc_evt <= '0;
  endtask : acc

  task automatic pri(input logic [3:0] v);
    @(posedge clk);
    pri_load <= 1'b1;
    pri_value <= v;
    @(posedge clk);
    pri_load <= 1'b0;
    @(negedge clk);
  endtask : pri

  task automatic addr_gen_unit(input cscr_pkg::cscr_agu_req_t r);
    @(posedge clk);
    agu_req <= r;
    @(posedge clk);
    agu_req <= '0;
    @(negedge clk);
  endtask : addr_gen_unit

  // Expected status after one add or subtract; subtract is a + ~b + 1
  function automatic logic [15:0] alu_status(input logic bm, input logic sb, input logic [15:0] a,
                                             input logic [15:0] b);
    logic [15:0] bb;
    logic [16:0] s;
    logic [8:0] lo;
    int t;
    bb = sb ? ~b : b;
    t = bm ? 7 : 15;
    lo = bm ? ({5'h0, a[3:0]} + {5'h0, bb[3:0]} + {8'h0, sb}) : ({1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h0, sb});
    s = bm ? ({9'h0, a[7:0]} + {9'h0, bb[7:0]} + {16'h0, sb}) : ({1'b0, a} + {1'b0, bb} + {16'h0, sb});
    alu_status = 16'h0;
    alu_status[8] = bm ? lo[4] : lo[8];
    alu_status[3] = s[t];
    alu_status[2] = (a[t] == bb[t]) && (s[t] != a[t]);
    alu_status[1] = bm ? (s[7:0] == 8'h0) : (s[15:0] == 16'h0);
    alu_status[0] = s[t + 1];
  endfunction : alu_status

  // A hang counts as a mismatch and ends the run
  initial begin
    repeat (20000) @(posedge clk);
    check(32'h0, 32'h1);
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic bm;
    logic sb;
    logic [15:0] a;
    logic [15:0] b;
    cscr_pkg::cscr_agu_req_t r;
    void'($urandom(36131));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    sfr_rd(2'h0, 16'h0000);
    sfr_rd(2'h1, 16'h0020);
    check(32'(core_ctrl.sat_dw_en), 32'h1);
    $display("Test reset done");
    for (int i = 0; i < 24; i++) begin
      bm = i[0];
      sb = i[1];
      a = (i == 0) ? 16'hffff : 16'($urandom);
      b = (i == 0) ? 16'h0001 : ((i % 5 == 0) ? a : 16'($urandom));
      alu(bm, sb, a, b);
      sfr_rd(2'h0, alu_status(bm, sb, a, b));
    end
    $display("Test alu flags done");
    sfr_wr(2'h0, 16'h0000);
    acc('{upd_a: 1'b1, ov_a: 1'b1, sat_a: 1'b1, default: 1'b0});
    sfr_rd(2'h0, 16'hac00);
    acc('{upd_a: 1'b1, default: 1'b0});
    sfr_rd(2'h0, 16'h2400);
    acc('{upd_b: 1'b1, ov_b: 1'b1, sat_b: 1'b1, default: 1'b0});
    sfr_rd(2'h0, 16'h7c00);
    sfr_wr(2'h0, 16'h4800);
    sfr_rd(2'h0, 16'h4800);
    sfr_wr(2'h0, 16'h3400);
    sfr_rd(2'h0, 16'h3400);
    $display("Test accumulator flags done");
    sfr_wr(2'h0, 16'h00e0);
    sfr_rd(2'h0, 16'h00e0);
    check(32'({cpu_prio, user_blk}), 32'h0f);
    @(posedge clk);
    nest_dis <= 1'b1;
    sfr_wr(2'h0, 16'h0040);
    sfr_rd(2'h0, 16'h00e0);
    @(posedge clk);
    nest_dis <= 1'b0;
    sfr_wr(2'h0, 16'h0040);
    sfr_rd(2'h0, 16'h0040);
    for (int i = 0; i < 16; i++) begin
      pri(4'(i));
      check(32'({cpu_prio, user_blk}), 32'({4'(i), i >= 7}));
    end
    sfr_rd(2'h1, 16'h0028);
    sfr_wr(2'h1, 16'h0020);
    check(32'(cpu_prio), 32'h7);
    $display("Test priority done");
    @(posedge clk);
    loop_stat <= '{do_active: 1'b1, rep_active: 1'b1, nest_depth: 3'h5, stack_frame: 1'b1};
    sfr_wr(2'h0, 16'h0000);
    sfr_wr(2'h1, 16'hffff);
    // Early termination is a one-cycle strobe, still up half a cycle after the write edge
    check(32'(core_ctrl), 32'h3ff);
    sfr_rd(2'h1, 16'hb5f7);
    check(32'(core_ctrl.clamp_range_select), 32'h1);
    sfr_rd(2'h0, 16'h0210);
    sfr_wr(2'h1, 16'h0020);
    check(32'(core_ctrl.clamp_range_select), 32'h0);
    @(posedge clk);
    loop_stat <= '0;
    loop_start <= 24'($urandom);
    sfr_wr(2'h2, 16'hffff);
    sfr_wr(2'h3, 16'hffff);
    sfr_rd(2'h2, loop_start[15:0]);
    sfr_rd(2'h3, {8'h00, loop_start[23:16]});
    $display("Test control and loop start done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      act_ctx <= 2'($urandom_range(2));
      mm_idx <= 4'(i);
      @(posedge clk);
      @(negedge clk);
      check(32'(mm_bank), 32'((i == 15) ? 2'h0 : act_ctx));
    end
    $display("Test context done");
    @(posedge clk);
    x_cfg <= '{mod_en: 1'b1, mod_start: 16'h1000, mod_end: 16'h100f};
    y_cfg <= '{mod_en: 1'b1, mod_start: 16'h2000, mod_end: 16'h200f};
    r = '0;
    r.valid = 1'b1;
    r.dual = 1'b1;
    r.x_ea = 16'h100e;
    r.x_step = 16'h0002;
    r.y_ea = 16'h2000;
    r.y_step = 16'hfffe;
    addr_gen_unit(r);
    check({agu_out.x_next, agu_out.y_next}, {16'h1000, 16'h200e});
    @(posedge clk);
    x_cfg <= '0;
    r = '0;
    r.valid = 1'b1;
    r.x_ea = 16'h0008;
    r.brev_en = 1'b1;
    r.brev_mod = 16'h0010;
    addr_gen_unit(r);
    check(32'(agu_out.x_next), 32'h0018);
    r = '0;
    r.valid = 1'b1;
    r.x_ea = 16'h8abc;
    r.win_en = 1'b1;
    r.win_page = 9'h1a5;
    addr_gen_unit(r);
    check(32'({agu_out.x_prog_hit, agu_out.y_valid, agu_out.prog_word}), 32'({2'h2, 9'h1a5, 14'h055e}));
    for (int i = 0; i < 12; i++) begin
      r = cscr_pkg::cscr_agu_req_t'(93'({$urandom, $urandom, $urandom}));
      r.valid = 1'b1;
      addr_gen_unit(r);
    end
    $display("Test address generation done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    sfr_rd(2'h0, 16'h0000);
    $display("Test second reset done");
    finish_test();
  end
endmodule : tb_cscr_regs
`default_nettype wire
